// File: shared/sgp_map.svh
// Register offsets, field positions, reset values and timing counts for the servo supervisor.
`ifndef SGP_MAP_SVH
`define SGP_MAP_SVH

// ==========================================================================
// Register byte offsets
// ==========================================================================
`define SGP_GAIN_SETUP_OFS    12'h000
`define SGP_T12_OFS           12'h004
`define SGP_T21_OFS           12'h008
`define SGP_WAIT1_OFS         12'h00C
`define SGP_WAIT2_OFS         12'h010
`define SGP_PIP_SEL_OFS       12'h014
`define SGP_PIP_TRQ_OFS       12'h018
`define SGP_PIP_SPD_OFS       12'h01C
`define SGP_PIP_ACC_OFS       12'h020
`define SGP_PIP_DEV_OFS       12'h024
`define SGP_TRQ_ADD_OFS       12'h028
`define SGP_FWD_COMP_OFS      12'h02C
`define SGP_REV_COMP_OFS      12'h030
`define SGP_STATUS_OFS        12'h034
`define SGP_NUM_RW            13

// ==========================================================================
// Field positions and readback masks
// ==========================================================================
`define SGP_SETUP_EN_BIT      0
`define SGP_SETUP_SEL_LSB     4
`define SGP_SETUP_MASK        32'h0000_00F1
`define SGP_MASK16            32'h0000_FFFF
`define SGP_MASK3             32'h0000_0007
`define SGP_RESET_VAL         32'h0000_0000

// ==========================================================================
// Timing: clock period and the 0.1 ms time base
// ==========================================================================
`define SGP_CLK_PERIOD_NS     100
`define SGP_TICK_NS           100000
`define SGP_TICK_CYCLES       (`SGP_TICK_NS / `SGP_CLK_PERIOD_NS)
`define SGP_TICKS_PER_MS      10
`define SGP_RESP_OKAY         2'b00
`define SGP_RESP_SLVERR       2'b10

`endif

// File: shared/sgp_pkg.sv
// Types shared by the servo gain and PI/P supervisor.
package sgp_pkg;

  // ========================================================================
  // Gain switching sequence states
  // ========================================================================
  typedef enum logic [2:0] {
    SGP_ST_FIRST,
    SGP_ST_WAIT2,
    SGP_ST_RAMP2,
    SGP_ST_SECOND,
    SGP_ST_WAIT1,
    SGP_ST_RAMP1
  } sgp_state_e;

  // ========================================================================
  // Internal servo status flags used as gain switching triggers
  // ========================================================================
  typedef struct packed {
    logic pos_complete;
    logic near_position;
    logic cmd_filter_zero;
    logic pulse_input_on;
    logic gain_switch_in;
    logic zero_speed;
    logic motor_rotating;
    logic speed_coincide;
  } sgp_cond_s;

  // ========================================================================
  // Servo quantities, all signed two's complement
  // ========================================================================
  typedef struct packed {
    logic signed [15:0] torque_cmd;
    logic signed [15:0] speed_cmd;
    logic signed [15:0] accel;
    logic signed [31:0] pos_err;
  } sgp_servo_s;

  typedef logic [31:0] sgp_word_t;

endpackage

// File: core/sgp_core.sv
// Servo gain set switching, speed loop PI/P selection and torque compensation.
//
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "sgp_map.svh"
// ==========================================================================
// Notes on behaviour
// - Setup enable 0 holds gains; 1 switches automatically.
// - Trigger chosen from ten condition codes.
// - First-to-second transition lasts programmed milliseconds.
// - Second-to-first transition has its own time.
// - Separate wait delay before each switch direction.
// - Select 0: torque above threshold gives P.
// - Select 1: speed above threshold gives P.
// - Acceleration select: above threshold gives P.
// - Deviation select: error above threshold gives P.
// - Constant offset added to torque command.
// - Forward compensation added when moving forward.
// - Reverse compensation subtracted when moving in reverse.
// ==========================================================================
module sgp_core
  import sgp_pkg::*;
#(
  parameter int TICK_CYCLES = `SGP_TICK_CYCLES
) (
  // Clock and reset.
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // AXI4-Lite write address and data.
  input  wire logic [11:0]        s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  // AXI4-Lite read channels.
  input  wire logic [11:0]        s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  // Servo status and quantities.
  input  wire sgp_cond_s          cond_in,
  input  wire sgp_servo_s         servo_in,
  input  wire logic               motor_fwd,
  input  wire logic               motor_rev,
  // Gain, loop mode and torque outputs.
  output logic                    gain_second,
  output logic                    gain_ramping,
  output logic [15:0]             gain_ramp_ms,
  output logic [15:0]             gain_ramp_total,
  output logic                    speed_p_only,
  output logic signed [15:0]      torque_cmd_out
);

  // ====================
  // Register storage
  // ====================
  sgp_word_t          reg_ff [`SGP_NUM_RW];
  sgp_word_t          nxt_reg [`SGP_NUM_RW];
  logic               bvalid_ff;
  logic [1:0]         bresp_ff;
  logic               rvalid_ff;
  logic [1:0]         rresp_ff;
  logic [31:0]        rdata_ff;
  logic               wr_go;
  logic [3:0]         wr_idx;
  logic               wr_hit;
  logic [3:0]         rd_idx;
  logic               rd_hit;
  logic               rd_stat;
  sgp_word_t          rd_mask;
  sgp_word_t          status_word;

  // Timing and sequencing state.
  sgp_state_e         state_ff;
  sgp_state_e         nxt_state;
  logic [15:0]        tick_cnt_ff;
  logic               tick;
  logic [3:0]         ms_div_ff;
  logic               ms_tick;
  logic [15:0]        wait_ff;
  logic [15:0]        ramp_ff;
  logic               cond_hit;
  logic               p_only_ff;
  logic               p_only_nxt;
  logic signed [15:0] trq_ff;
  logic signed [17:0] trq_sum;

  // Decoded fields.
  logic               gs_enable;
  logic [3:0]         gs_select;
  logic [2:0]         pip_select;

  assign gs_enable  = reg_ff[0][`SGP_SETUP_EN_BIT];
  assign gs_select  = reg_ff[0][`SGP_SETUP_SEL_LSB +: 4];
  assign pip_select = reg_ff[5][2:0];

  // ====================
  // AXI4-Lite slave
  // ====================
  // Address and data are taken together, so neither channel can run ahead.
  assign wr_go         = s_axi_awvalid & s_axi_wvalid & ~bvalid_ff;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = ~rvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rresp   = rresp_ff;
  assign s_axi_rdata   = rdata_ff;

  // Word decode; the status word sits just past the writable block.
  assign wr_idx  = s_axi_awaddr[5:2];
  assign wr_hit  = (s_axi_awaddr[11:6] == 6'd0) && (s_axi_awaddr[1:0] == 2'd0)
                   && (wr_idx < 4'(`SGP_NUM_RW));
  assign rd_idx  = s_axi_araddr[5:2];
  assign rd_stat = (s_axi_araddr == `SGP_STATUS_OFS);
  assign rd_hit  = (s_axi_araddr[11:6] == 6'd0) && (s_axi_araddr[1:0] == 2'd0)
                   && (rd_idx < 4'(`SGP_NUM_RW));

  // Readback mask keeps unused high bits at zero.
  always_comb begin
    if (rd_idx == 4'd0) begin
      rd_mask = `SGP_SETUP_MASK;
    end else if (rd_idx == 4'd5) begin
      rd_mask = `SGP_MASK3;
    end else begin
      rd_mask = `SGP_MASK16;
    end
  end

  // Byte lanes of each register follow wstrb.
  for (genvar gi = 0; gi < `SGP_NUM_RW; gi++) begin : g_reg
    always_comb begin
      nxt_reg[gi] = reg_ff[gi];
      for (int b = 0; b < 4; b++) begin
        if (wr_go && wr_hit && (wr_idx == 4'(gi)) && s_axi_wstrb[b]) begin
          nxt_reg[gi][8*b +: 8] = s_axi_wdata[8*b +: 8];
        end
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        reg_ff[gi] <= `SGP_RESET_VAL;
      end else begin
        reg_ff[gi] <= nxt_reg[gi];
      end
    end
  end

  // Write response; unmapped addresses and the status word answer SLVERR.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= `SGP_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= wr_hit ? `SGP_RESP_OKAY : `SGP_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Status word: state, gain flags, loop mode and ramp progress.
  assign status_word = {gain_ramp_ms, 8'h00, 1'b0, state_ff, p_only_ff,
                        gain_ramping, gain_second, cond_hit};

  // Read data is registered so the answer follows one cycle after arready.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rresp_ff  <= `SGP_RESP_OKAY;
      rdata_ff  <= 32'h0000_0000;
    end else if (s_axi_arvalid && !rvalid_ff) begin
      rvalid_ff <= 1'b1;
      if (rd_stat) begin
        rresp_ff <= `SGP_RESP_OKAY;
        rdata_ff <= status_word;
      end else if (rd_hit) begin
        rresp_ff <= `SGP_RESP_OKAY;
        rdata_ff <= reg_ff[rd_idx] & rd_mask;
      end else begin
        rresp_ff <= `SGP_RESP_SLVERR;
        rdata_ff <= 32'h0000_0000;
      end
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // ====================
  // Time base: 0.1 ms tick and 1 ms tick
  // ====================
  assign tick    = (tick_cnt_ff == 16'(TICK_CYCLES - 1));
  assign ms_tick = tick && (ms_div_ff == 4'(`SGP_TICKS_PER_MS - 1));

  // Free running so every delay shares one time base; phase error is under one tick for waits and under one millisecond for transitions.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_ff <= 16'h0000;
      ms_div_ff   <= 4'h0;
    end else begin
      tick_cnt_ff <= tick ? 16'h0000 : tick_cnt_ff + 16'h0001;
      if (tick) begin
        ms_div_ff <= ms_tick ? 4'h0 : ms_div_ff + 4'h1;
      end
    end
  end

  // ====================
  // Gain switching trigger
  // ====================
  always_comb begin
    unique case (gs_select)
      4'd0:    cond_hit = cond_in.pos_complete;
      4'd1:    cond_hit = ~cond_in.pos_complete;
      4'd2:    cond_hit = cond_in.near_position;
      4'd3:    cond_hit = ~cond_in.near_position;
      4'd4:    cond_hit = cond_in.cmd_filter_zero & ~cond_in.pulse_input_on;
      4'd5:    cond_hit = cond_in.pulse_input_on;
      4'd6:    cond_hit = cond_in.gain_switch_in;
      4'd7:    cond_hit = cond_in.zero_speed;
      4'd8:    cond_hit = cond_in.motor_rotating;
      4'd9:    cond_hit = cond_in.speed_coincide;
      default: cond_hit = 1'b0;
    endcase
  end

  // ====================
  // Gain switching sequence
  // ====================
  // A ramp, once started, completes whatever the trigger does; only clearing setup enable cuts it short and drops to the first set.
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      SGP_ST_FIRST: begin
        if (cond_hit) begin
          nxt_state = SGP_ST_WAIT2;
        end
      end
      SGP_ST_WAIT2: begin
        if (!cond_hit) begin
          nxt_state = SGP_ST_FIRST;
        end else if (wait_ff >= reg_ff[4][15:0]) begin
          nxt_state = SGP_ST_RAMP2;
        end
      end
      SGP_ST_RAMP2: begin
        if (ramp_ff >= reg_ff[1][15:0]) begin
          nxt_state = SGP_ST_SECOND;
        end
      end
      SGP_ST_SECOND: begin
        if (!cond_hit) begin
          nxt_state = SGP_ST_WAIT1;
        end
      end
      SGP_ST_WAIT1: begin
        if (cond_hit) begin
          nxt_state = SGP_ST_SECOND;
        end else if (wait_ff >= reg_ff[3][15:0]) begin
          nxt_state = SGP_ST_RAMP1;
        end
      end
      SGP_ST_RAMP1: begin
        if (ramp_ff >= reg_ff[2][15:0]) begin
          nxt_state = SGP_ST_FIRST;
        end
      end
    endcase
    if (!gs_enable) begin
      nxt_state = SGP_ST_FIRST;
    end
  end

  // State register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= SGP_ST_FIRST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Wait delay counted in 0.1 ms ticks, restarted on every state change.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wait_ff <= 16'h0000;
    end else if (nxt_state != state_ff) begin
      wait_ff <= 16'h0000;
    end else if (tick && wait_ff != 16'hFFFF) begin
      wait_ff <= wait_ff + 16'h0001;
    end
  end

  // Ramp progress counted in whole milliseconds.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ramp_ff <= 16'h0000;
    end else if (nxt_state != state_ff) begin
      ramp_ff <= 16'h0000;
    end else if (ms_tick && ramp_ff != 16'hFFFF) begin
      ramp_ff <= ramp_ff + 16'h0001;
    end
  end

  // Gain outputs; the loop interpolates between sets from elapsed and total time.
  always_comb begin
    gain_second     = (state_ff == SGP_ST_SECOND) || (state_ff == SGP_ST_WAIT1)
                      || (state_ff == SGP_ST_RAMP2);
    gain_ramping    = (state_ff == SGP_ST_RAMP2) || (state_ff == SGP_ST_RAMP1);
    gain_ramp_ms    = gain_ramping ? ramp_ff : 16'h0000;
    gain_ramp_total = (state_ff == SGP_ST_RAMP1) ? reg_ff[2][15:0] : reg_ff[1][15:0];
  end

  // ====================
  // Speed loop PI / P selection
  // ====================
  // Magnitudes are compared so both directions share one threshold; equal stays PI.
  always_comb begin
    unique case (pip_select)
      3'd0:    p_only_nxt = (servo_in.torque_cmd < 0 ? -servo_in.torque_cmd
                             : servo_in.torque_cmd) > $signed({1'b0, reg_ff[6][14:0]});
      3'd1:    p_only_nxt = (servo_in.speed_cmd < 0 ? -servo_in.speed_cmd
                             : servo_in.speed_cmd) > $signed({1'b0, reg_ff[7][14:0]});
      3'd2:    p_only_nxt = (servo_in.accel < 0 ? -servo_in.accel
                             : servo_in.accel) > $signed({1'b0, reg_ff[8][14:0]});
      3'd3:    p_only_nxt = (servo_in.pos_err < 0 ? -servo_in.pos_err
                             : servo_in.pos_err) > $signed({16'h0000, reg_ff[9][15:0]});
      default: p_only_nxt = 1'b0;
    endcase
  end

  // Registered mode flag.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      p_only_ff <= 1'b0;
    end else begin
      p_only_ff <= p_only_nxt;
    end
  end

  assign speed_p_only = p_only_ff;

  // ====================
  // Torque compensation
  // ====================
  // Widened sum then saturation, so a large offset cannot wrap the command's sign.
  always_comb begin
    trq_sum = 18'(servo_in.torque_cmd) + 18'($signed(reg_ff[10][15:0]));
    if (motor_fwd) begin
      trq_sum = trq_sum + 18'($signed(reg_ff[11][15:0]));
    end else if (motor_rev) begin
      trq_sum = trq_sum - 18'($signed(reg_ff[12][15:0]));
    end
  end

  // Registered, saturated torque command.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trq_ff <= 16'sh0000;
    end else if (trq_sum > 18'sh07FFF) begin
      trq_ff <= 16'sh7FFF;
    end else if (trq_sum < -18'sh08000) begin
      trq_ff <= -16'sh8000;
    end else begin
      trq_ff <= trq_sum[15:0];
    end
  end

  assign torque_cmd_out = trq_ff;

endmodule

// File: test/sgp_core_chk.sv
// Concurrent checks on the servo supervisor's bus handshakes and gain outputs.
`timescale 1ns/10ps
module sgp_core_chk (
  // Clock and reset.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Bus handshakes.
  input  wire logic        s_axi_awvalid,
  input  wire logic        s_axi_awready,
  input  wire logic        s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [31:0] s_axi_rdata,
  // Gain outputs.
  input  wire logic        gain_second,
  input  wire logic        gain_ramping,
  input  wire logic [15:0] gain_ramp_ms,
  input  wire logic [15:0] gain_ramp_total
);
  // ====================
  // Bus checks
  // ====================
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // A taken request is answered on the very next edge.
  sequence s_wr_take;
    s_axi_awvalid && s_axi_wvalid && s_axi_awready && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_wr_answer: assert property (s_wr_take |=> s_axi_bvalid)
    else $error("write response late");
  a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read data late");
  a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_rd_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_wr_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  // ====================
  // Gain transition checks
  // ====================
  // A move into the second set always passes through a timed transition.
  a_second_ramp: assert property ($rose(gain_second) |-> gain_ramping)
    else $error("second set without transition");
  a_total_steady: assert property (
    gain_ramping && $past(gain_ramping) |-> $stable(gain_ramp_total))
    else $error("transition length changed");
  a_ms_step: assert property (
    gain_ramping && $past(gain_ramping) |-> (gain_ramp_ms == $past(gain_ramp_ms)) ||
    (gain_ramp_ms == $past(gain_ramp_ms) + 16'h0001))
    else $error("elapsed time jumped");
  a_ms_bound: assert property (gain_ramping |-> gain_ramp_ms <= gain_ramp_total)
    else $error("transition overran");
  a_ms_idle: assert property (!gain_ramping |-> gain_ramp_ms == 16'h0000)
    else $error("elapsed time outside transition");
endmodule

bind sgp_core sgp_core_chk u_sgp_core_chk (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .gain_second, .gain_ramping,
  .gain_ramp_ms, .gain_ramp_total);

// File: test/sgp_core_tb.sv
// Self-checking bench for the servo gain and PI/P supervisor.
`timescale 1ns/10ps
`include "sgp_map.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module sgp_core_tb
  import sgp_pkg::*;
;
  // ====================
  // Signals
  // ====================
  typedef struct {
    int          src;
    logic [33:0] val;
  } sgp_note_s;
  localparam logic [1:0] OK  = `SGP_RESP_OKAY;
  localparam logic [1:0] ERR = `SGP_RESP_SLVERR;
  sgp_note_s          notes[$];
  int                 err_total = 0;
  int                 compares  = 0;
  logic               smp_stb   = 1'b0;
  logic               aclk      = 1'b0;
  logic               aresetn   = 1'b0;
  logic [11:0]        awaddr    = 12'h000;
  logic               awvalid   = 1'b0;
  logic [31:0]        wdata     = 32'h0000_0000;
  logic [3:0]         wstrb     = 4'h0;
  logic               wvalid    = 1'b0;
  logic               bready    = 1'b0;
  logic [11:0]        araddr    = 12'h000;
  logic               arvalid   = 1'b0;
  logic               rready    = 1'b0;
  sgp_cond_s          cond      = '0;
  sgp_servo_s         servo     = '0;
  logic               mfwd      = 1'b0;
  logic               mrev      = 1'b0;
  logic               awready, wready, bvalid, arready, rvalid, gsec, gramp, p_only;
  logic [1:0]         bresp, rresp;
  logic [31:0]        rdata;
  logic [15:0]        ramp_ms, ramp_total;
  logic signed [15:0] torque_out;

  // Short time base: one millisecond is 40 cycles.
  sgp_core #(.TICK_CYCLES(4)) u_sgp_core (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .cond_in(cond), .servo_in(servo), .motor_fwd(mfwd), .motor_rev(mrev),
    .gain_second(gsec), .gain_ramping(gramp), .gain_ramp_ms(ramp_ms),
    .gain_ramp_total(ramp_total), .speed_p_only(p_only), .torque_cmd_out(torque_out));

  // Free-running 10 MHz clock.
  initial begin
    forever #50 aclk = ~aclk;
  end

  // ====================
  // Helpers
  // ====================
  // Output value by source number.
  function automatic logic [33:0] port_val(input int src);
    case (src)
      0: return {bresp, 32'h0000_0000};
      1: return {rresp, rdata};
      2: return {33'h0, gsec};
      3: return {33'h0, p_only};
      4: return {18'h0, torque_out};
      5: return {33'h0, gramp};
      6: return {18'h0, ramp_total};
      7: return {33'h0, awvalid && awready};
      8: return {33'h0, bvalid};
      9: return {33'h0, arvalid && arready};
      default: return {33'h0, rvalid};
    endcase
  endfunction

  // Status that makes trigger code c true or false; codes 1 and 3 test the inverse.
  function automatic sgp_cond_s cond_for(input int c, input logic on);
    int b;
    b = (c < 4) ? 7 - c / 2 : 9 - c;
    cond_for = '0;
    cond_for[b] = (c == 1 || c == 3) ? !on : on;
  endfunction

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Bounded wait; running out is a mismatch and ends the run.
  task automatic wait_for(input int src, input logic [33:0] lvl, input int lim);
    int n;
    n = 0;
    while (port_val(src) !== lvl) begin
      @(posedge aclk);
      n++;
      if (n > lim) begin
        `CHK(port_val(src), lvl)
        wrap_up();
      end
    end
  endtask

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] r);
    @(posedge aclk);
    notes.push_back(sgp_note_s'{0, {r, 32'h0000_0000}});
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    wait_for(7, 34'h1, 50);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    wait_for(8, 34'h1, 50);
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    notes.push_back(sgp_note_s'{1, {r, d}});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    wait_for(9, 34'h1, 50);
    arvalid <= 1'b0;
    wait_for(10, 34'h1, 50);
    rready <= 1'b0;
  endtask

  // Notes an expected output level; the watcher compares it one edge later.
  task automatic expect_out(input int src, input logic [33:0] v);
    @(posedge aclk);
    notes.push_back(sgp_note_s'{src, v});
    smp_stb <= 1'b1;
    @(posedge aclk);
    smp_stb <= 1'b0;
  endtask

  // Watcher: takes the oldest note whenever a response or a probe appears.
  always @(posedge aclk) begin
    sgp_note_s n;
    if ((bvalid && bready) || (rvalid && rready) || smp_stb) begin
      if (notes.size() == 0) begin
        err_total++;
      end else begin
        n = notes.pop_front();
        `CHK(port_val(n.src), n.val)
      end
    end
  end

  // ====================
  // Main sequence
  // ====================
  initial begin
    logic signed [15:0] v, tq, off, fc, rc, ex;
    void'($urandom(38));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values, readback masks and refused accesses.
    for (int i = 0; i < 14; i++) axi_rd(12'(4 * i), 32'h0000_0000, OK);
    for (int i = 0; i < 13; i++) begin
      axi_wr(12'(4 * i), 32'hFFFF_FFFF, 4'hF, OK);
      axi_rd(12'(4 * i), (i == 0) ? `SGP_SETUP_MASK : (i == 5) ? `SGP_MASK3 : `SGP_MASK16, OK);
      axi_wr(12'(4 * i), 32'h0000_0000, 4'hF, OK);
    end
    axi_wr(`SGP_STATUS_OFS, 32'h0000_0001, 4'hF, ERR);
    axi_wr(12'h002, 32'h0000_0001, 4'hF, ERR);
    axi_wr(12'h100, 32'h0000_0001, 4'hF, ERR);
    axi_rd(12'h038, 32'h0000_0000, ERR);
    axi_wr(`SGP_PIP_TRQ_OFS, 32'h1234_5678, 4'h1, OK);
    axi_rd(`SGP_PIP_TRQ_OFS, 32'h0000_0078, OK);
    // PI/P selection: only the selected quantity sits near the threshold, the rest above it.
    for (int i = 0; i < 4; i++) axi_wr(`SGP_PIP_TRQ_OFS + 12'(4 * i), 32'h0000_0064, 4'hF, OK);
    for (int s = 0; s < 5; s++) begin
      axi_wr(`SGP_PIP_SEL_OFS, 32'(s), 4'hF, OK);
      for (int k = 0; k < 4; k++) begin
        v = (k == 0) ? 16'sh0064 : (k == 1) ? 16'sh0065 : (k == 2) ? 16'shFF9B : 16'sh0032;
        servo <= '{(s == 0) ? v : 16'sh00C8, (s == 1) ? v : 16'sh00C8,
                   (s == 2) ? v : 16'sh00C8, (s == 3) ? 32'(v) : 32'sh0000_00C8};
        expect_out(3, {33'h0, (s < 4) && (k == 1 || k == 2)});
      end
    end
    // Torque compensation in all four direction combinations, random amounts.
    for (int k = 0; k < 8; k++) begin
      tq = $signed(16'($urandom_range(200))) - 16'sh0064;
      off = 16'($urandom_range(50));
      fc = 16'($urandom_range(50));
      rc = 16'($urandom_range(50));
      axi_wr(`SGP_TRQ_ADD_OFS, {16'h0000, off}, 4'hF, OK);
      axi_wr(`SGP_FWD_COMP_OFS, {16'h0000, fc}, 4'hF, OK);
      axi_wr(`SGP_REV_COMP_OFS, {16'h0000, rc}, 4'hF, OK);
      ex = tq + off + (k[0] ? fc : (k[1] ? -rc : 16'sh0000));
      servo <= '{tq, 16'sh0000, 16'sh0000, 32'sh0000_0000};
      mfwd <= k[0];
      mrev <= k[1];
      expect_out(4, {18'h0, ex});
    end
    // Every trigger code, with zero waits and zero transition times.
    for (int c = 0; c < 10; c++) begin
      axi_wr(`SGP_GAIN_SETUP_OFS, 32'((c << `SGP_SETUP_SEL_LSB) | 1), 4'hF, OK);
      cond <= cond_for(c, 1'b0);
      repeat (6) @(posedge aclk);
      expect_out(2, 34'h0);
      cond <= cond_for(c, 1'b1);
      repeat (6) @(posedge aclk);
      expect_out(2, 34'h1);
    end
    // Timed switch both ways from the first set: waits 0.3 ms, transitions 2 ms and 3 ms.
    axi_wr(`SGP_GAIN_SETUP_OFS, 32'h0000_0000, 4'hF, OK);
    axi_wr(`SGP_T12_OFS, 32'h0000_0002, 4'hF, OK);
    axi_wr(`SGP_T21_OFS, 32'h0000_0003, 4'hF, OK);
    axi_wr(`SGP_WAIT1_OFS, 32'h0000_0003, 4'hF, OK);
    axi_wr(`SGP_WAIT2_OFS, 32'h0000_0003, 4'hF, OK);
    axi_wr(`SGP_GAIN_SETUP_OFS, 32'h0000_0061, 4'hF, OK);
    cond <= cond_for(6, 1'b1);
    expect_out(2, 34'h0);
    wait_for(5, 34'h1, 60);
    expect_out(6, 34'h2);
    expect_out(2, 34'h1);
    repeat (28) @(posedge aclk);
    expect_out(5, 34'h1);
    wait_for(5, 34'h0, 120);
    expect_out(2, 34'h1);
    cond <= cond_for(6, 1'b0);
    expect_out(5, 34'h0);
    wait_for(5, 34'h1, 60);
    expect_out(2, 34'h0);
    expect_out(6, 34'h3);
    wait_for(5, 34'h0, 130);
    // Switching off drops back to the first set and stays there.
    cond <= cond_for(6, 1'b1);
    wait_for(2, 34'h1, 60);
    axi_wr(`SGP_GAIN_SETUP_OFS, 32'h0000_0060, 4'hF, OK);
    expect_out(2, 34'h0);
    repeat (100) @(posedge aclk);
    expect_out(2, 34'h0);
    wrap_up();
  end
endmodule
